// File: design/dcc_pkg.sv
/*
  Shared constants and types of the dual converter control block and its controller.
  Assumes both ends run a 100 MHz clk_i with a synchronous active-high reset.
*/
package dcc_pkg;
  // Sample and code widths
  localparam int CODE_W = 8;
  localparam int IN_W = 10;
  localparam logic signed [IN_W-1:0] IN_MIN = -10'sd128;
  localparam logic signed [IN_W-1:0] IN_MAX = 10'sd127;
  localparam logic signed [IN_W-1:0] IN_MID = 10'sd128;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ONES = 8'hff;
  // Pipeline and calibration timing in input clock cycles
  localparam int PIPE_LAT = 13;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CAL_LOW_MIN = 8'h50;
  localparam logic [CNT_W-1:0] CAL_HIGH_MIN = 8'h50;
  localparam int CAL_CYCLES = 140000;
  localparam logic [1:0] POR_SETTLE = 2'h3;
  // Controller timing
  localparam longint CLK_HZ = 100000000;
  localparam longint RECAL_WAIT_S = 20;
  localparam longint PWR_WAIT_CYC = RECAL_WAIT_S * CLK_HZ;
  localparam int CMD_MARGIN = 16;
  localparam int CMD_HOLD = int'(CAL_LOW_MIN) + CMD_MARGIN;
  // Controller register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 8'h14;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_RANGE_BIT = 0;
  localparam int CTRL_LEVEL_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int IRQ_CAL_DONE = 0;
  localparam int IRQ_OOR = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // State machines
  typedef enum logic [1:0] {DS_POR, DS_IDLE, DS_CAL} dcc_dev_st_t;
  typedef enum logic [1:0] {HS_WAIT, HS_IDLE, HS_LOW, HS_HIGH} dcc_host_st_t;
endpackage : dcc_pkg

// File: design/dcc_link_if.sv
/*
  Pin-level link between the converter end and its controller end.
  Assumes each end samples the other's pins on its own clock.
*/
interface dcc_link_if;
  logic cal_pin;
  logic full_scale_range_select;
  logic level_reduced;
  logic calibration_running;
  logic out_of_range;
  logic output_data_clock;
  logic [7:0] a_pri;
  logic [7:0] a_dly;
  logic [7:0] b_pri;
  logic [7:0] b_dly;
  modport dev (
    input cal_pin, full_scale_range_select, level_reduced,
    output calibration_running, out_of_range, output_data_clock,
    output a_pri, a_dly, b_pri, b_dly
  );
  modport host (
    output cal_pin, full_scale_range_select, level_reduced,
    input calibration_running, out_of_range, output_data_clock,
    input a_pri, a_dly, b_pri, b_dly
  );
endinterface : dcc_link_if

// File: design/dcc_dev_end.sv
/*
  Converter end: clamping, shared out-of-range flag, 13-cycle pipeline,
  1:2 demultiplexing onto primary and delayed buses, output data clock,
  drive level select and the self-calibration sequencer.
  Assumes the sample inputs come from logic on clk_i and the control pins
  come from another clock domain.
*/
// Added by the designer: the register addresses and register access over AXI4-Lite.
// Operation
// R1 - Below negative full scale outputs all zeros
// R2 - Above positive full scale outputs all ones
// R3 - One flag when either channel clamps
// R4 - Each channel demultiplexed onto two buses
// R5 - Receiver interleaves both buses to full rate
// R6 - Calibrate at power-up and on command
// R7 - Command: low 80 cycles, then high 80
// R8 - Pin high at power-up suppresses calibration
// R9 - Controller recalibrates after range select changes
// R10 - Controller calibrates twenty seconds after power-up
// R11 - Data update follows output clock falling edge
// R12 - New result every cycle, fixed latency
// R13 - Selectable normal or reduced drive level
// R14 - Running status high during any calibration
// R15 - Outputs invalid during calibration, receiver ignores
// R16 - Primary bus 13 cycles, delayed 14
// R17 - Low and high counts separate, low restarts
module dcc_dev_end #(
  parameter int CAL_CYCLES = dcc_pkg::CAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [dcc_pkg::IN_W-1:0] chan_a_i,
  input wire logic signed [dcc_pkg::IN_W-1:0] chan_b_i,
  output logic range_level_o,
  output logic drive_reduced_o,
  dcc_link_if.dev link
);
  localparam int CAL_W = $clog2(CAL_CYCLES + 1);
  localparam int WORD_W = dcc_pkg::CODE_W + 1;

  // Clamp a sample to an offset binary code with its out-of-range bit on top
  function automatic logic [WORD_W-1:0] dcc_clamp(
    input logic signed [dcc_pkg::IN_W-1:0] v
  );
    logic signed [dcc_pkg::IN_W-1:0] sum;
    sum = v + dcc_pkg::IN_MID;
    if (v < dcc_pkg::IN_MIN) begin
      return {1'b1, dcc_pkg::CODE_ZERO}; // [R1]
    end else if (v > dcc_pkg::IN_MAX) begin
      return {1'b1, dcc_pkg::CODE_ONES}; // [R2]
    end
    return {1'b0, sum[dcc_pkg::CODE_W-1:0]};
  endfunction : dcc_clamp

  logic [2:0] pin_m_r;
  logic [2:0] pin_s_r;
  logic [WORD_W-1:0] pipe_a_r [dcc_pkg::PIPE_LAT+1];
  logic [WORD_W-1:0] pipe_b_r [dcc_pkg::PIPE_LAT+1];
  logic out_clk_r;
  logic [7:0] a_pri_r;
  logic [7:0] a_dly_r;
  logic [7:0] b_pri_r;
  logic [7:0] b_dly_r;
  logic oor_r;
  logic [dcc_pkg::CNT_W-1:0] low_cnt_r;
  logic [dcc_pkg::CNT_W-1:0] high_cnt_r;
  logic [1:0] por_cnt_r;
  logic [CAL_W-1:0] cal_cnt_r;
  dcc_pkg::dcc_dev_st_t st_r;
  dcc_pkg::dcc_dev_st_t st_nxt;
  logic cal_run_r;
  logic range_r;
  logic level_r;

  // Two-stage synchroniser for the control pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_r <= 3'h0;
      pin_s_r <= 3'h0;
    end else begin
      pin_m_r <= {link.level_reduced, link.full_scale_range_select, link.cal_pin};
      pin_s_r <= pin_m_r;
    end
  end

  wire cal_s = pin_s_r[0];
  wire range_s = pin_s_r[1];
  wire level_s = pin_s_r[2];

  // Stage 0 takes a clamped sample on every clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_a_r[0] <= '0;
      pipe_b_r[0] <= '0;
    end else begin
      pipe_a_r[0] <= dcc_clamp(chan_a_i); // [R12]
      pipe_b_r[0] <= dcc_clamp(chan_b_i); // [R12]
    end
  end

  // Remaining pipeline stages shift once per clock
  for (genvar i = 1; i <= dcc_pkg::PIPE_LAT; i++) begin : g_pipe
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pipe_a_r[i] <= '0;
        pipe_b_r[i] <= '0;
      end else begin
        pipe_a_r[i] <= pipe_a_r[i-1]; // [R12]
        pipe_b_r[i] <= pipe_b_r[i-1];
      end
    end
  end

  // Taps: primary bus sees sample t-13, delayed bus sample t-14
  wire [WORD_W-1:0] tap_a_pri = pipe_a_r[dcc_pkg::PIPE_LAT-1]; // [R16]
  wire [WORD_W-1:0] tap_a_dly = pipe_a_r[dcc_pkg::PIPE_LAT]; // [R16]
  wire [WORD_W-1:0] tap_b_pri = pipe_b_r[dcc_pkg::PIPE_LAT-1];
  wire [WORD_W-1:0] tap_b_dly = pipe_b_r[dcc_pkg::PIPE_LAT];
  wire oor_any = tap_a_pri[WORD_W-1] | tap_a_dly[WORD_W-1]
               | tap_b_pri[WORD_W-1] | tap_b_dly[WORD_W-1]; // [R3]

  // Buses load when the output clock falls, so every other clock
  wire upd = out_clk_r; // [R11]

  // Output data clock at half the input clock rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_clk_r <= 1'b0;
    end else begin
      out_clk_r <= ~out_clk_r;
    end
  end

  // Demultiplexed output buses and shared flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_pri_r <= '0;
      a_dly_r <= '0;
      b_pri_r <= '0;
      b_dly_r <= '0;
      oor_r <= 1'b0;
    end else if (upd) begin
      a_pri_r <= tap_a_pri[7:0]; // [R4]
      a_dly_r <= tap_a_dly[7:0]; // [R4]
      b_pri_r <= tap_b_pri[7:0]; // [R4]
      b_dly_r <= tap_b_dly[7:0]; // [R4]
      oor_r <= oor_any; // [R3]
    end
  end

  // Command detector counts the synchronised pin's low and high phases
  wire low_done = (low_cnt_r == dcc_pkg::CAL_LOW_MIN);
  wire [dcc_pkg::CNT_W-1:0] low_inc = low_cnt_r + 8'h01;
  wire [dcc_pkg::CNT_W-1:0] high_inc = high_cnt_r + 8'h01;
  wire high_early = (high_cnt_r != 8'h00);
  wire cmd_fire = cal_s & low_done & (high_inc == dcc_pkg::CAL_HIGH_MIN); // [R7]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
    end else if (!cal_s) begin
      low_cnt_r <= high_early ? 8'h01 : (low_done ? low_cnt_r : low_inc); // [R17]
      high_cnt_r <= '0;
    end else if (!low_done || cmd_fire) begin
      low_cnt_r <= '0; // [R17]
      high_cnt_r <= '0;
    end else begin
      high_cnt_r <= high_inc; // [R17]
    end
  end

  // Calibration sequencer next state
  wire por_done = (por_cnt_r == dcc_pkg::POR_SETTLE);
  wire cal_last = (cal_cnt_r == CAL_W'(CAL_CYCLES - 1));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dcc_pkg::DS_POR: begin
        if (por_done) begin
          st_nxt = cal_s ? dcc_pkg::DS_IDLE : dcc_pkg::DS_CAL; // [R6] [R8]
        end
      end
      dcc_pkg::DS_IDLE: begin
        if (cmd_fire) begin
          st_nxt = dcc_pkg::DS_CAL; // [R6] [R7]
        end
      end
      dcc_pkg::DS_CAL: begin
        if (cal_last) begin
          st_nxt = dcc_pkg::DS_IDLE;
        end
      end
      default: begin
        st_nxt = dcc_pkg::DS_POR;
      end
    endcase
  end

  // Sequencer state and counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= dcc_pkg::DS_POR;
      por_cnt_r <= '0;
      cal_cnt_r <= '0;
      cal_run_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      por_cnt_r <= por_done ? por_cnt_r : por_cnt_r + 2'h1;
      cal_cnt_r <= (st_r == dcc_pkg::DS_CAL && !cal_last) ? cal_cnt_r + CAL_W'(1) : '0;
      cal_run_r <= (st_nxt == dcc_pkg::DS_CAL); // [R14] [R15]
    end
  end

  // Range select and drive level follow their pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      range_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      range_r <= range_s;
      level_r <= level_s; // [R13]
    end
  end

  // Link and user-side outputs
  assign link.calibration_running = cal_run_r;
  assign link.out_of_range = oor_r;
  assign link.output_data_clock = out_clk_r;
  assign link.a_pri = a_pri_r;
  assign link.a_dly = a_dly_r;
  assign link.b_pri = b_pri_r;
  assign link.b_dly = b_dly_r;
  assign range_level_o = range_r;
  assign drive_reduced_o = level_r;
endmodule : dcc_dev_end

// File: design/dcc_host_end.sv
/*
  Controller end: AXI4-Lite registers, calibration command generator,
  capture and interleave of the demultiplexed buses, interrupt status.
  Assumes the link pins come from another clock domain and software
  drives the AXI4-Lite port on clk_i.
*/
module dcc_host_end #(
  parameter longint PWR_WAIT = dcc_pkg::PWR_WAIT_CYC,
  parameter int HOLD = dcc_pkg::CMD_HOLD
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [dcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic recal_i,
  output logic [7:0] stream_a_o,
  output logic [7:0] stream_b_o,
  output logic stream_valid_o,
  output logic irq_o,
  dcc_link_if.host link
);
  localparam int LW = 35;

  logic [LW-1:0] lnk_m_r;
  logic [LW-1:0] lnk_s_r;
  logic clk_prev_r;
  logic run_prev_r;
  logic [15:0] pri_r;
  logic pend_r;
  logic [7:0] sa_r;
  logic [7:0] sb_r;
  logic sv_r;
  logic [1:0] ctrl_r;
  logic req_r;
  logic [dcc_pkg::IRQ_W-1:0] stat_r;
  logic [dcc_pkg::IRQ_W-1:0] en_r;
  dcc_pkg::dcc_host_st_t st_r;
  dcc_pkg::dcc_host_st_t st_nxt;
  logic [63:0] cnt_r;
  logic pin_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Two-stage synchroniser for everything arriving on the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lnk_m_r <= '0;
      lnk_s_r <= '0;
    end else begin
      lnk_m_r <= {link.calibration_running, link.out_of_range, link.output_data_clock,
                  link.a_dly, link.a_pri, link.b_dly, link.b_pri};
      lnk_s_r <= lnk_m_r;
    end
  end

  wire run_s = lnk_s_r[34];
  wire oor_s = lnk_s_r[33];
  wire clk_s = lnk_s_r[32];
  wire rise = clk_s & ~clk_prev_r;
  wire take = rise & ~run_s; // [R15]
  wire ev_oor = take & oor_s;
  wire ev_done = run_prev_r & ~run_s;

  // Capture on the output clock rising edge; delayed word is the earlier sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_prev_r <= 1'b0;
      run_prev_r <= 1'b0;
      pri_r <= '0;
      pend_r <= 1'b0;
      sa_r <= '0;
      sb_r <= '0;
      sv_r <= 1'b0;
    end else begin
      clk_prev_r <= clk_s;
      run_prev_r <= run_s;
      pend_r <= take;
      sv_r <= take | pend_r; // [R5]
      if (take) begin
        sa_r <= lnk_s_r[31:24]; // [R5]
        sb_r <= lnk_s_r[15:8];
        pri_r <= {lnk_s_r[23:16], lnk_s_r[7:0]};
      end else if (pend_r) begin
        sa_r <= pri_r[15:8]; // [R5]
        sb_r <= pri_r[7:0];
      end
    end
  end

  // Register bus decode
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  wire rd_go = s_axi_arvalid & ~rvalid_r;
  wire wr_lo = wr_go & s_axi_wstrb[0];
  wire wr_ctrl = wr_lo & (s_axi_awaddr == dcc_pkg::REG_CTRL);
  wire wr_cmd = wr_lo & (s_axi_awaddr == dcc_pkg::REG_CMD);
  wire wr_clr = wr_lo & (s_axi_awaddr == dcc_pkg::REG_IRQ_CLR);
  wire wr_en = wr_lo & (s_axi_awaddr == dcc_pkg::REG_IRQ_EN);
  wire wr_hit = (s_axi_awaddr == dcc_pkg::REG_CTRL) | (s_axi_awaddr == dcc_pkg::REG_CMD)
              | (s_axi_awaddr == dcc_pkg::REG_IRQ_CLR) | (s_axi_awaddr == dcc_pkg::REG_IRQ_EN);
  wire range_chg = wr_ctrl & (s_axi_wdata[dcc_pkg::CTRL_RANGE_BIT] != ctrl_r[0]);
  wire new_req = (wr_cmd & s_axi_wdata[0]) | range_chg | recal_i; // [R9]
  wire [dcc_pkg::IRQ_W-1:0] ev = {ev_oor, ev_done};
  wire [dcc_pkg::IRQ_W-1:0] clr = wr_clr ? s_axi_wdata[dcc_pkg::IRQ_W-1:0] : '0;
  wire [31:0] rd_mux =
      (s_axi_araddr == dcc_pkg::REG_CTRL) ? {30'h0, ctrl_r} :
      (s_axi_araddr == dcc_pkg::REG_STATUS) ? {29'h0, oor_s, req_r, run_s} :
      (s_axi_araddr == dcc_pkg::REG_IRQ_STAT) ? {30'h0, stat_r} :
      (s_axi_araddr == dcc_pkg::REG_IRQ_EN) ? {30'h0, en_r} : 32'h0;
  wire rd_hit = (s_axi_araddr == dcc_pkg::REG_CTRL) | (s_axi_araddr == dcc_pkg::REG_STATUS)
              | (s_axi_araddr == dcc_pkg::REG_IRQ_STAT) | (s_axi_araddr == dcc_pkg::REG_IRQ_EN);

  // Bus responses, control, request and interrupt registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= dcc_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= dcc_pkg::RESP_OKAY;
      ctrl_r <= dcc_pkg::CTRL_RST;
      req_r <= 1'b1; // [R10]
      stat_r <= '0;
      en_r <= '0;
    end else begin
      bvalid_r <= wr_go | (bvalid_r & ~s_axi_bready);
      bresp_r <= wr_go ? (wr_hit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR) : bresp_r;
      rvalid_r <= rd_go | (rvalid_r & ~s_axi_rready);
      rdata_r <= rd_go ? rd_mux : rdata_r;
      rresp_r <= rd_go ? (rd_hit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR) : rresp_r;
      ctrl_r <= wr_ctrl ? s_axi_wdata[1:0] : ctrl_r;
      req_r <= new_req | (req_r & (st_r != dcc_pkg::HS_IDLE)); // [R9]
      stat_r <= (stat_r & ~clr) | ev;
      en_r <= wr_en ? s_axi_wdata[dcc_pkg::IRQ_W-1:0] : en_r;
    end
  end

  // Command generator: wait, then pin low and high for HOLD + 1 cycles each
  wire cnt_end = (st_r == dcc_pkg::HS_WAIT) ? (cnt_r >= 64'(PWR_WAIT)) : (cnt_r >= 64'(HOLD));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      dcc_pkg::HS_WAIT: if (cnt_end) st_nxt = dcc_pkg::HS_IDLE; // [R10]
      dcc_pkg::HS_IDLE: if (req_r) st_nxt = dcc_pkg::HS_LOW;
      dcc_pkg::HS_LOW: if (cnt_end) st_nxt = dcc_pkg::HS_HIGH; // [R7]
      dcc_pkg::HS_HIGH: if (cnt_end) st_nxt = dcc_pkg::HS_IDLE; // [R7]
      default: st_nxt = dcc_pkg::HS_WAIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= dcc_pkg::HS_WAIT;
      cnt_r <= '0;
      pin_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 64'h0 : cnt_r + 64'h1;
      pin_r <= (st_nxt == dcc_pkg::HS_HIGH);
    end
  end

  // Outputs
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign stream_a_o = sa_r;
  assign stream_b_o = sb_r;
  assign stream_valid_o = sv_r;
  assign irq_o = |(stat_r & en_r);
  assign link.cal_pin = pin_r;
  assign link.full_scale_range_select = ctrl_r[dcc_pkg::CTRL_RANGE_BIT];
  assign link.level_reduced = ctrl_r[dcc_pkg::CTRL_LEVEL_BIT];
endmodule : dcc_host_end

// File: tb/dcc_link_assertions.sv
/*
  Checker for the link between the converter end and the controller end.
  Assumes one clk_i domain with synchronous active-high reset on both ends.
*/
module dcc_chk #(
  parameter int CAL_CYCLES = 300
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic signed [9:0] chan_a_i,
  input wire logic signed [9:0] chan_b_i,
  input wire logic cal_pin,
  input wire logic calibration_running,
  input wire logic out_of_range,
  input wire logic output_data_clock,
  input wire logic [7:0] a_pri,
  input wire logic [7:0] a_dly,
  input wire logic [7:0] b_pri,
  input wire logic [7:0] b_dly
);
  logic [7:0] up_r, up_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
  logic [31:0] run_r, run_nxt;

  // Expected output code of one sample, with clamping at both ends
  function automatic logic [7:0] code_of(input logic signed [9:0] v);
    logic [9:0] s;
    s = v + dcc_pkg::IN_MID;
    if (v < dcc_pkg::IN_MIN) return dcc_pkg::CODE_ZERO;
    if (v > dcc_pkg::IN_MAX) return dcc_pkg::CODE_ONES;
    return s[7:0];
  endfunction : code_of

  function automatic logic clip(input logic signed [9:0] v);
    return (v < dcc_pkg::IN_MIN) || (v > dcc_pkg::IN_MAX);
  endfunction : clip

  // Counters: time since reset and pin phase lengths saturate, run length does not
  assign up_nxt = (up_r == 8'hff) ? up_r : up_r + 8'h01;
  assign hi_nxt = !cal_pin ? 8'h00 : ((hi_r == 8'hff) ? hi_r : hi_r + 8'h01);
  assign lo_nxt = cal_pin ? 8'h00 : ((lo_r == 8'hff) ? lo_r : lo_r + 8'h01);
  assign run_nxt = calibration_running ? run_r + 32'h1 : 32'h0;

  always_ff @(posedge clk_i) begin
    up_r <= rst_i ? 8'h00 : up_nxt;
    hi_r <= rst_i ? 8'h00 : hi_nxt;
    lo_r <= rst_i ? 8'h00 : lo_nxt;
    run_r <= rst_i ? 32'h0 : run_nxt;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_pri_latency: assert property (
    $fell(output_data_clock) && up_r > 8'd16 |-> a_pri == code_of($past(chan_a_i, 14))
      && b_pri == code_of($past(chan_b_i, 14))) else $error("primary word wrong");
  chk_dly_latency: assert property (
    $fell(output_data_clock) && up_r > 8'd16 |-> a_dly == code_of($past(chan_a_i, 15))
      && b_dly == code_of($past(chan_b_i, 15))) else $error("delayed word wrong");
  chk_oor_shared: assert property (
    $fell(output_data_clock) && up_r > 8'd16 |-> out_of_range == (clip($past(chan_a_i, 14))
      || clip($past(chan_b_i, 14)) || clip($past(chan_a_i, 15))
      || clip($past(chan_b_i, 15)))) else $error("range flag wrong");
  chk_update_edge: assert property (
    !$fell(output_data_clock) |-> $stable({a_pri, a_dly, b_pri, b_dly, out_of_range}))
    else $error("bus moved off clock fall");
  chk_odc_toggle: assert property (
    up_r > 8'd2 |-> output_data_clock != $past(output_data_clock))
    else $error("output clock stuck");
  chk_cal_length: assert property (
    $fell(calibration_running) |-> run_r == CAL_CYCLES) else $error("calibration length");
  chk_powerup_cal: assert property (
    $fell(rst_i) |-> ##[2:8] calibration_running) else $error("no power-up calibration");
  chk_cmd_high: assert property (
    $rose(calibration_running) && up_r > 8'd16 |-> hi_r >= dcc_pkg::CAL_HIGH_MIN)
    else $error("calibration without command");
  chk_cmd_low: assert property (
    $rose(cal_pin) |-> lo_r >= dcc_pkg::CAL_LOW_MIN) else $error("command low too short");
  chk_cmd_hold: assert property (
    $fell(cal_pin) |-> hi_r >= dcc_pkg::CAL_HIGH_MIN) else $error("command high too short");

  // Main scenarios reached
  cov_cal: cover property ($rose(calibration_running));
  cov_oor: cover property ($rose(out_of_range));
  cov_cmd: cover property ($fell(cal_pin));
endmodule : dcc_chk

// File: tb/test_dual_adc_calibration_and_output_control.sv
/*
  Self-checking bench: both ends joined by one link, plus a second converter end
  whose calibration pin the bench drives itself.
  Assumes a 100 MHz clk_i and synchronous active-high reset.
*/
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module test_dual_adc_calibration_and_output_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_N = 300;
  localparam logic [1:0] OK = dcc_pkg::RESP_OKAY;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic signed [9:0] ch_a = '0, ch_b = '0;
  logic [7:0] awaddr = '0, araddr = '0, st_a, st_b, da, db;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, recal = 0, seen_x = 0;
  logic awready, wready, bvalid, arready, rvalid, st_v, irq, rng, red, prev;
  logic [1:0] bresp, rresp;
  int num_errors = 0, n_tests = 0, cycles = 0;
  dcc_link_if link ();
  dcc_link_if link_x ();
  wire run_m = link.calibration_running;
  wire run_x = link_x.calibration_running;

  dcc_dev_end #(.CAL_CYCLES(CAL_N)) u_dcc_dev_end (.clk_i(clk_i), .rst_i(rst_i),
    .chan_a_i(ch_a), .chan_b_i(ch_b), .range_level_o(rng), .drive_reduced_o(red), .link(link));
  dcc_dev_end #(.CAL_CYCLES(CAL_N)) u_dcc_dev_end_x (.clk_i(clk_i), .rst_i(rst_i),
    .chan_a_i(ch_a), .chan_b_i(ch_b), .range_level_o(), .drive_reduced_o(), .link(link_x));
  dcc_host_end #(.PWR_WAIT(200), .HOLD(dcc_pkg::CMD_HOLD)) u_dcc_host_end (.clk_i(clk_i),
    .rst_i(rst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .recal_i(recal),
    .stream_a_o(st_a), .stream_b_o(st_b), .stream_valid_o(st_v), .irq_o(irq), .link(link));
  dcc_chk #(.CAL_CYCLES(CAL_N)) u_dcc_chk (.clk_i(clk_i), .rst_i(rst_i), .chan_a_i(ch_a),
    .chan_b_i(ch_b), .cal_pin(link.cal_pin), .calibration_running(link.calibration_running),
    .out_of_range(link.out_of_range), .output_data_clock(link.output_data_clock),
    .a_pri(link.a_pri), .a_dly(link.a_dly), .b_pri(link.b_pri), .b_dly(link.b_dly));

  // Clock, hang limit and watch on the second converter end
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (!rst_i && run_x === 1'b1) seen_x <= 1'b1;
    if (cycles == 12000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge clk_i);
    while (awready !== 1'b1 || wready !== 1'b1) @(posedge clk_i);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    @(posedge clk_i);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk_i);
    while (arready !== 1'b1) @(posedge clk_i);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
    @(posedge clk_i);
  endtask : axi_rd

  task automatic wait_run(input bit x, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((x ? run_x : run_m) !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("cal running", lvl, x ? run_x : run_m)
  endtask : wait_run

  task automatic t_powerup();
    wait_run(0, 1'b1, 10);
    wait_run(0, 1'b0, CAL_N + 5);
    wait_run(0, 1'b1, 400);
    wait_run(0, 1'b0, CAL_N + 5);
    axi_rd(dcc_pkg::REG_CTRL, 32'h0, OK);
    axi_rd(dcc_pkg::REG_IRQ_EN, 32'h0, OK);
    axi_rd(dcc_pkg::REG_STATUS, 32'h0, OK);
    axi_rd(dcc_pkg::REG_IRQ_STAT, 32'h1, OK);
    axi_wr(dcc_pkg::REG_IRQ_CLR, 32'h3, OK);
    axi_wr(dcc_pkg::REG_IRQ_EN, 32'h1, OK);
    `CHK("irq", 1'b0, irq)
  endtask : t_powerup

  task automatic t_range();
    axi_wr(dcc_pkg::REG_CTRL, 32'h3, OK);
    axi_rd(dcc_pkg::REG_CTRL, 32'h3, OK);
    repeat (4) @(posedge clk_i);
    `CHK("range pin", 1'b1, link.full_scale_range_select)
    `CHK("level pin", 1'b1, link.level_reduced)
    `CHK("range out", 1'b1, rng)
    `CHK("level out", 1'b1, red)
    wait_run(0, 1'b1, 300);
    wait_run(0, 1'b0, CAL_N + 5);
    repeat (3) @(posedge clk_i);
    `CHK("irq", 1'b1, irq)
    axi_wr(dcc_pkg::REG_IRQ_CLR, 32'h1, OK);
    `CHK("irq", 1'b0, irq)
  endtask : t_range

  task automatic t_clamp();
    logic signed [9:0] va [5];
    logic [7:0] ec [5];
    logic eo [5];
    va = '{-10'sd200, -10'sd128, 10'sd0, 10'sd200, 10'sd127};
    ec = '{8'h00, 8'h00, 8'h80, 8'hff, 8'hff};
    eo = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++) begin
      ch_a <= va[i];
      ch_b <= va[(i + 1) % 5];
      repeat (20) @(posedge clk_i);
      `CHK("a_pri", ec[i], link.a_pri)
      `CHK("a_dly", ec[i], link.a_dly)
      `CHK("b_pri", ec[(i + 1) % 5], link.b_pri)
      `CHK("oor", eo[i], link.out_of_range)
      while (st_v !== 1'b1) @(posedge clk_i);
      `CHK("stream a", ec[i], st_a)
    end
    ch_a <= 10'sd0;
    ch_b <= 10'sd0;
    repeat (20) @(posedge clk_i);
    axi_rd(dcc_pkg::REG_IRQ_STAT, 32'h2, OK);
    `CHK("irq masked", 1'b0, irq)
    axi_wr(dcc_pkg::REG_IRQ_EN, 32'h3, OK);
    `CHK("irq", 1'b1, irq)
    axi_wr(dcc_pkg::REG_IRQ_CLR, 32'h2, OK);
    `CHK("irq", 1'b0, irq)
  endtask : t_clamp

  task automatic t_ramp();
    prev = 1'b0;
    for (int i = 0; i < 120; i++) begin
      ch_a <= 10'(i - 60);
      ch_b <= 10'(60 - i);
      @(posedge clk_i);
      if (i > 40 && st_v === 1'b1 && prev === 1'b1) begin
        `CHK("pair a", 8'(da + 8'h01), st_a)
        `CHK("pair b", 8'(db - 8'h01), st_b)
      end
      da = st_a;
      db = st_b;
      prev = st_v;
    end
  endtask : t_ramp

  task automatic t_cmd();
    axi_wr(dcc_pkg::REG_CMD, 32'h1, OK);
    wait_run(0, 1'b1, 300);
    wait_run(0, 1'b0, CAL_N + 5);
    recal <= 1'b1;
    @(posedge clk_i);
    recal <= 1'b0;
    wait_run(0, 1'b1, 300);
    wait_run(0, 1'b0, CAL_N + 5);
    axi_rd(8'h20, 32'h0, dcc_pkg::RESP_SLVERR);
    axi_wr(8'h20, 32'h1, dcc_pkg::RESP_SLVERR);
  endtask : t_cmd

  task automatic pin_x(input logic lvl, input int n);
    link_x.cal_pin <= lvl;
    repeat (n) @(posedge clk_i);
  endtask : pin_x

  task automatic t_rogue();
    `CHK("held-high start", 1'b0, seen_x)
    pin_x(1'b0, 50);
    pin_x(1'b1, 20);
    pin_x(1'b0, 60);
    pin_x(1'b1, 90);
    `CHK("early high", 1'b0, seen_x)
    pin_x(1'b0, 90);
    pin_x(1'b1, 90);
    `CHK("full command", 1'b1, run_x)
    pin_x(1'b0, 1);
    wait_run(1, 1'b0, CAL_N + 5);
  endtask : t_rogue

  // Main sequence
  initial begin
    link_x.cal_pin = 1'b1;
    link_x.full_scale_range_select = 1'b0;
    link_x.level_reduced = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_powerup();
    t_range();
    t_clamp();
    t_ramp();
    t_cmd();
    t_rogue();
    give_verdict();
  end
endmodule : test_dual_adc_calibration_and_output_control
